// ==== core/icr_consts.svh ====
`ifndef ICR_CONSTS_SVH
`define ICR_CONSTS_SVH
`define ICR_CMD_OFFSET      8'h04
`define ICR_CMD_RESET       16'h0000
`define ICR_CMD_WMASK       16'h0146
`define ICR_BIT_ERR_REPORT  8
`define ICR_BIT_PARITY      6
`define ICR_BIT_MASTER      2
`define ICR_BIT_MEM_TARGET  1
`define ICR_LANE_LO         0
`define ICR_LANE_HI         1
`endif

// ==== core/icr_pkg.sv ====
package icr_pkg;
    typedef enum logic [1:0] {
        ICR_REQ_MEM,
        ICR_REQ_IO,
        ICR_REQ_MSG,
        ICR_REQ_CPL
    } icr_req_kind_t;
endpackage : icr_pkg

// ==== core/icr_command_control.sv ====
`include "icr_consts.svh"
module icr_command_control
    import icr_pkg::*;
(
    input  wire logic          SYS_CLK,
    input  wire logic          RST_N,
    input  wire logic          CFG_WR,
    input  wire logic [7:0]    CFG_ADDR,
    input  wire logic [1:0]    CFG_BE,
    input  wire logic [15:0]   CFG_WDATA,
    output logic      [15:0]   CFG_RDATA,
    input  wire logic          PARITY_ERR_IN,
    input  wire logic          PARITY_ERR_ON_WRITE,
    output logic               ERR_MSG_SEND,
    output logic               CAP_ERR_DETECT,
    input  wire logic          UP_REQ_VALID,
    input  wire icr_req_kind_t UP_REQ_KIND,
    output logic               UP_REQ_ALLOW,
    input  wire logic          LINK_MEM_HIT,
    output logic               LINK_MEM_ACCEPT,
    output logic               LINK_MEM_ABORT,
    output logic               ERROR_REPORT_ENABLE,
    output logic               PARITY_CHECK_ENABLE,
    output logic               MASTER_ENABLE,
    output logic               MEMORY_TARGET_ENABLE
);
    // Reset value of the whole register, viewed bit by bit
    localparam logic [15:0] CMD_RESET = `ICR_CMD_RESET;
    localparam logic [15:0] CMD_WMASK = `ICR_CMD_WMASK;

    // Write decode
    logic          cfg_sel;
    logic          wr_lane_lo;
    logic          wr_lane_hi;

    // Writable fields of the command register
    logic          err_report_reg;
    logic          err_report_next;
    logic          parity_reg;
    logic          parity_next;
    logic          master_reg;
    logic          master_next;
    logic          mem_target_reg;
    logic          mem_target_next;

    // Error reporting pulses
    logic          par_hit;
    logic          err_msg_reg;
    logic          err_msg_next;
    logic          cap_err_reg;
    logic          cap_err_next;

    // Read view and gates
    logic [15:0]   cmd_view;
    logic          kind_gated;
    logic          up_allow;
    logic          mem_accept;
    logic          mem_abort;

    always_comb begin
        cfg_sel    = 1'b0;
        wr_lane_lo = 1'b0;
        wr_lane_hi = 1'b0;
        if (CFG_ADDR == `ICR_CMD_OFFSET) begin
            cfg_sel = 1'b1;
        end
        if (CFG_WR && cfg_sel) begin
            wr_lane_lo = CFG_BE[`ICR_LANE_LO];
            wr_lane_hi = CFG_BE[`ICR_LANE_HI];
        end
    end

    // writable bits only
    // Only this enable lives in the upper lane
    always_comb begin
        err_report_next = err_report_reg;
        if (wr_lane_hi) begin
            err_report_next = CFG_WDATA[`ICR_BIT_ERR_REPORT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            err_report_reg <= CMD_RESET[`ICR_BIT_ERR_REPORT];
        end else begin
            err_report_reg <= err_report_next;
        end
    end

    always_comb begin
        parity_next = parity_reg;
        if (wr_lane_lo) begin
            parity_next = CFG_WDATA[`ICR_BIT_PARITY];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            parity_reg <= CMD_RESET[`ICR_BIT_PARITY];
        end else begin
            parity_reg <= parity_next;
        end
    end

    always_comb begin
        master_next = master_reg;
        if (wr_lane_lo) begin
            master_next = CFG_WDATA[`ICR_BIT_MASTER];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            master_reg <= CMD_RESET[`ICR_BIT_MASTER];
        end else begin
            master_reg <= master_next;
        end
    end

    always_comb begin
        mem_target_next = mem_target_reg;
        if (wr_lane_lo) begin
            mem_target_next = CFG_WDATA[`ICR_BIT_MEM_TARGET];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mem_target_reg <= CMD_RESET[`ICR_BIT_MEM_TARGET];
        end else begin
            mem_target_reg <= mem_target_next;
        end
    end

    // Read-side errors always count; write-side ones need checking on
    always_comb begin
        par_hit      = 1'b0;
        err_msg_next = 1'b0;
        cap_err_next = 1'b0;
        if (PARITY_ERR_IN) begin
            par_hit = ~PARITY_ERR_ON_WRITE | parity_reg;
        end
        cap_err_next = par_hit;
        err_msg_next = par_hit & err_report_reg;
    end

    // Pulses, not sticky: the status register keeps the history
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            err_msg_reg <= 1'b0;
            cap_err_reg <= 1'b0;
        end else begin
            err_msg_reg <= err_msg_next;
            cap_err_reg <= cap_err_next;
        end
    end

    always_comb begin
        cmd_view                      = CMD_RESET;
        cmd_view[`ICR_BIT_ERR_REPORT] = err_report_reg;
        cmd_view[`ICR_BIT_PARITY]     = parity_reg;
        cmd_view[`ICR_BIT_MASTER]     = master_reg;
        cmd_view[`ICR_BIT_MEM_TARGET] = mem_target_reg;
        // Mask again so no reset value can show a fixed bit
        cmd_view = cmd_view & CMD_WMASK;
    end

    // Other offsets read zero; this block holds no other register
    always_comb begin
        CFG_RDATA = 16'h0000;
        if (cfg_sel) begin
            CFG_RDATA = cmd_view;
        end
    end

    always_comb begin
        kind_gated = 1'b0;
        case (UP_REQ_KIND)
            ICR_REQ_MEM: begin
                kind_gated = 1'b1;
            end
            ICR_REQ_IO: begin
                kind_gated = 1'b1;
            end
            ICR_REQ_CPL: begin
                kind_gated = 1'b0;
            end
            default: begin
                kind_gated = 1'b0;
            end
        endcase
    end

    always_comb begin
        up_allow = 1'b0;
        if (UP_REQ_VALID) begin
            up_allow = ~kind_gated | master_reg;
        end
    end

    always_comb begin
        mem_accept = 1'b0;
        mem_abort  = 1'b0;
        if (LINK_MEM_HIT) begin
            mem_accept = mem_target_reg;
            mem_abort  = ~mem_target_reg;
        end
    end

    assign UP_REQ_ALLOW         = up_allow;
    assign LINK_MEM_ACCEPT      = mem_accept;
    assign LINK_MEM_ABORT       = mem_abort;
    assign ERR_MSG_SEND         = err_msg_reg;
    assign CAP_ERR_DETECT       = cap_err_reg;
    assign ERROR_REPORT_ENABLE  = err_report_reg;
    assign PARITY_CHECK_ENABLE  = parity_reg;
    assign MASTER_ENABLE        = master_reg;
    assign MEMORY_TARGET_ENABLE = mem_target_reg;
endmodule : icr_command_control

// ==== verif/icr_chk_assertions.sv ====
module icr_chk import icr_pkg::*; (input wire logic SYS_CLK, RST_N,
    CFG_WR, PARITY_ERR_IN, PARITY_ERR_ON_WRITE, ERR_MSG_SEND,
    CAP_ERR_DETECT, UP_REQ_VALID, UP_REQ_ALLOW, LINK_MEM_HIT,
    LINK_MEM_ABORT, LINK_MEM_ACCEPT, ERROR_REPORT_ENABLE, PARITY_CHECK_ENABLE,
    MASTER_ENABLE, MEMORY_TARGET_ENABLE,
    input wire logic [7:0] CFG_ADDR, input wire logic [1:0] CFG_BE,
    input wire logic [15:0] CFG_WDATA, CFG_RDATA,
    input wire icr_req_kind_t UP_REQ_KIND);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    wire w = CFG_WR && CFG_ADDR == 8'h04;
    wire e = PARITY_ERR_IN && (!PARITY_ERR_ON_WRITE || PARITY_CHECK_ENABLE);
    property p_zero; CFG_ADDR == 8'h04 |-> !(CFG_RDATA & 16'hFEB9); endproperty
    a_zero: assert property (p_zero) else $error("fixed bits");
    property p_wr; w && CFG_BE[1] |=> ERROR_REPORT_ENABLE == $past(CFG_WDATA[8]);
    endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_wr_lo; w && CFG_BE[0] |=>
        {PARITY_CHECK_ENABLE, MASTER_ENABLE, MEMORY_TARGET_ENABLE} ==
        $past({CFG_WDATA[6], CFG_WDATA[2], CFG_WDATA[1]});
    endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("low lane lost");
    property p_hold; !w |=> $stable({PARITY_CHECK_ENABLE, MASTER_ENABLE,
        ERROR_REPORT_ENABLE, MEMORY_TARGET_ENABLE});
    endproperty
    a_hold: assert property (p_hold) else $error("stray change");
    property p_err; e |=> CAP_ERR_DETECT &&
        ERR_MSG_SEND == $past(ERROR_REPORT_ENABLE);
    endproperty
    a_err: assert property (p_err) else $error("error pulse");
    property p_quiet; !e |=> !CAP_ERR_DETECT && !ERR_MSG_SEND; endproperty
    a_quiet: assert property (p_quiet) else $error("spurious");
    property p_bm; UP_REQ_VALID && UP_REQ_KIND <= ICR_REQ_IO |->
        UP_REQ_ALLOW == MASTER_ENABLE; endproperty
    a_bm: assert property (p_bm) else $error("master gate");
    property p_other; UP_REQ_VALID && UP_REQ_KIND > ICR_REQ_IO |-> UP_REQ_ALLOW;
    endproperty
    a_other: assert property (p_other) else $error("blocked");
    property p_mse; LINK_MEM_HIT |-> LINK_MEM_ABORT != MEMORY_TARGET_ENABLE
        && LINK_MEM_ACCEPT == MEMORY_TARGET_ENABLE;
    endproperty
    a_mse: assert property (p_mse) else $error("target gate");
    c_msg: cover property (ERR_MSG_SEND);
    c_abort: cover property (LINK_MEM_ABORT);
    c_wr: cover property (w ##1 MASTER_ENABLE);
endmodule : icr_chk
bind icr_command_control icr_chk chk_u (.*);

// ==== verif/icr_host_model.sv ====
module icr_host_model (
    output logic        wr    = 1'b0,
    output logic [7:0]  addr  = 8'h04,
    output logic [1:0]  be    = 2'h0,
    output logic [15:0] wdata = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // Called on a rising edge; a released strobe leaves data inverted
    task automatic put(input logic w, input logic [7:0] a,
                       input logic [1:0] b, input logic [15:0] d);
        {wr, addr, be, wdata} <= {w, a, b, d};
    endtask : put
endmodule : icr_host_model

// ==== verif/tb_interrupt_function_command_reg.sv ====
module tb_interrupt_function_command_reg;
    timeunit 1ns;
    timeprecision 1ns;
    import icr_pkg::*;
    logic sys_clk = 0, rst_n = 0, pe = 0, pw = 0, hit = 0, vld = 0, c;
    logic cap, msg, allow, abort, acc, wr;
    logic [1:0] b, be;
    logic [3:0] v;
    logic [7:0] a, addr;
    logic [15:0] d, wd, rd, ex = 16'h0000;
    icr_req_kind_t k = ICR_REQ_MEM;
    int seed = 6645, miscompares = 0, n_tests = 0, cyc = 0;
    icr_host_model host (.wr(wr), .addr(addr), .be(be), .wdata(wd));
    icr_command_control dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .CFG_WR(wr),
        .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rd),
        .PARITY_ERR_IN(pe), .PARITY_ERR_ON_WRITE(pw), .ERR_MSG_SEND(msg),
        .CAP_ERR_DETECT(cap), .UP_REQ_VALID(vld), .UP_REQ_KIND(k),
        .UP_REQ_ALLOW(allow), .LINK_MEM_HIT(hit), .LINK_MEM_ACCEPT(acc),
        .LINK_MEM_ABORT(abort), .ERROR_REPORT_ENABLE(), .MASTER_ENABLE(),
        .PARITY_CHECK_ENABLE(), .MEMORY_TARGET_ENABLE());
    always #5 sys_clk = ~sys_clk;
    function automatic logic [15:0] nxt(input logic [15:0] x);
        logic [15:0] m;
        m = 16'h0146 & {{8{b[1]}}, {8{b[0]}}};
        return (a == 8'h04) ? (x & ~m) | (d & m) : x;
    endfunction : nxt
    function automatic logic [15:0] gate(input logic [15:0] x);
        return 16'({v[3] && (k > ICR_REQ_IO || x[2]),
                    v[0] && !x[1], v[0] && x[1]});
    endfunction : gate
    task automatic check(input logic [15:0] g, input logic [15:0] x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : check
    task automatic end_of_test;
        $display("tests=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Run ceiling well above the 160 cycles the loop needs
    always @(posedge sys_clk) if (++cyc > 300) begin
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1;
        @(posedge sys_clk);
        #1 check(rd, 16'h0000);
        for (int i = 0; i < 80; i++) begin
            @(posedge sys_clk);
            {a, b, d, v} = {8'h04, 2'h3, 16'hFFFF, 4'hF};
            if (i > 0) {a, b, d, v} = {$random(seed), $random(seed)};
            if (i == 1) d = 16'h0000;
            if (i % 2) a = 8'h04;
            {pe, pw, hit} <= v[2:0];
            vld <= v[3];
            k <= icr_req_kind_t'(d[15:14]);
            host.put(1'b1, a, b, d);
            c = v[2] && (!v[1] || ex[6]);
            @(posedge sys_clk);
            host.put(1'b0, a, b, ~d);
            pe <= 1'b0;
            #1 check(16'({cap, msg}), 16'({c, c && ex[8]}));
            ex = nxt(ex);
            check(rd, a == 8'h04 ? ex : 16'h0000);
            check(16'({allow, abort, acc}), gate(ex));
            $display("test %0d done", i);
        end
        end_of_test();
    end
endmodule : tb_interrupt_function_command_reg
